// [common/xfr_cfg.svh]
`ifndef XFR_CFG_SVH
`define XFR_CFG_SVH

// Register byte offsets
`define XFR_OFS_CTRL      12'h000
`define XFR_OFS_STATUS    12'h004
`define XFR_OFS_LATCH     12'h008
`define XFR_OFS_IRQ_STAT  12'h00C
`define XFR_OFS_IRQ_MASK  12'h010

// Control fields
`define XFR_CTRL_RF_DIS    0
`define XFR_CTRL_LF_CLR    1
`define XFR_CTRL_LS_CLR    2
`define XFR_CTRL_PCS_RST   3
`define XFR_CTRL_RESET     4'h0

// Status and latch fields
`define XFR_ST_LF          0
`define XFR_ST_LINK        1
`define XFR_ST_RF_RX       2
`define XFR_ST_LF_RX       3
`define XFR_LATCH_LF       0
`define XFR_LATCH_LINK_LOW 1

// Interrupt fields
`define XFR_IRQ_LF         0
`define XFR_IRQ_RF         1
`define XFR_IRQ_LINK_UP    2
`define XFR_IRQ_RESET      3'h0

// Ordered set encoding
`define XFR_SEQ_CHAR       8'h9C
`define XFR_IDLE_CHAR      8'h07
`define XFR_SEQ_LF_LANE3   8'h01
`define XFR_SEQ_RF_LANE3   8'h02

// Consecutive columns needed to enter or leave a fault state
`define XFR_FAULT_COUNT    3'h4

`endif

// [common/xfr_pkg.sv]
package xfr_pkg;
    typedef enum logic [1:0] {
        XFR_LINK_OK    = 2'b00,
        XFR_LOCAL_FLT  = 2'b01,
        XFR_REMOTE_FLT = 2'b10
    } xfr_fault_t;
endpackage

// [rtl/xfr_seq_detect.sv]
`timescale 1ns/1ps
`default_nettype none
`include "xfr_cfg.svh"

module xfr_seq_detect (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Received column
    input  wire logic [31:0] rx_data,
    input  wire logic [3:0]  rx_ctrl,
    // Fault state seen from the link
    output var xfr_pkg::xfr_fault_t fault
);
    logic [31:0] col_data;
    logic [3:0]  col_ctrl;
    logic        is_seq;
    logic        is_lf;
    logic        is_rf;
    logic [2:0]  count;
    logic [2:0]  next_count;
    xfr_pkg::xfr_fault_t seen;
    xfr_pkg::xfr_fault_t next_fault;

    assign col_data = rx_data;
    assign col_ctrl = rx_ctrl;
    assign is_seq   = (col_ctrl == 4'h1) && (col_data[7:0] == `XFR_SEQ_CHAR)
                      && (col_data[23:8] == 16'h0000);
    assign is_lf    = is_seq && (col_data[31:24] == `XFR_SEQ_LF_LANE3);
    assign is_rf    = is_seq && (col_data[31:24] == `XFR_SEQ_RF_LANE3);
    assign seen     = is_lf ? xfr_pkg::XFR_LOCAL_FLT
                    : (is_rf ? xfr_pkg::XFR_REMOTE_FLT : xfr_pkg::XFR_LINK_OK);

    // Debounce so a single corrupt column does not flip the fault state
    always_comb begin
        next_fault = fault;
        next_count = count;
        if (seen == fault) begin
            next_count = 3'h0;
        end else if (count == `XFR_FAULT_COUNT - 3'h1) begin
            next_fault = seen;
            next_count = 3'h0;
        end else begin
            next_count = count + 3'h1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fault <= xfr_pkg::XFR_LINK_OK;
            count <= 3'h0;
        end else begin
            fault <= next_fault;
            count <= next_count;
        end
    end
endmodule
`default_nettype wire

// [rtl/xfr_reconcile.sv]
`timescale 1ns/1ps
`default_nettype none
`include "xfr_cfg.svh"

module xfr_reconcile (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Receiver health from PCS/transceiver
    input  wire logic        xcvr_locked,
    input  wire logic        rx_reset_active,
    input  wire logic        block_lock,
    input  wire logic        hi_ber,
    input  wire logic        ebuf_overflow,
    input  wire logic        ebuf_underflow,
    // Column from PCS decoder
    input  wire logic [31:0] pcs_rxd,
    input  wire logic [3:0]  pcs_rxc,
    // Column to MAC receive
    output logic      [31:0] mac_rxd,
    output logic      [3:0]  mac_rxc,
    // Column from MAC transmit
    input  wire logic [31:0] mac_txd,
    input  wire logic [3:0]  mac_txc,
    // Column to PCS encoder
    output logic      [31:0] pcs_txd,
    output logic      [3:0]  pcs_txc,
    // Status vector
    output logic             local_fault,
    output logic             link_status,
    output logic             local_fault_latched,
    output logic             link_status_latched,
    // Interrupt
    output logic             irq
);
    // ------------------------------------------------------------
    // Receiver health
    // ------------------------------------------------------------
    // Pin inputs: three stages, change accepted when last two agree
    localparam int NH = 6;
    logic [NH-1:0] h_raw;
    logic [NH-1:0] h_s1;
    logic [NH-1:0] h_s2;
    logic [NH-1:0] h_s3;
    logic [NH-1:0] h_ok;
    logic          ebuf_err;
    logic          rx_bad;
    logic [31:0]   lf_column;
    logic [31:0]   rf_column;
    logic [31:0]   idle_column;

    assign h_raw = {ebuf_underflow, ebuf_overflow, hi_ber, ~block_lock,
                    rx_reset_active, ~xcvr_locked};

    genvar gi;
    generate
        for (gi = 0; gi < NH; gi++) begin : g_sync
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    h_s1[gi] <= 1'b1;
                    h_s2[gi] <= 1'b1;
                    h_s3[gi] <= 1'b1;
                    h_ok[gi] <= 1'b1;
                end else begin
                    h_s1[gi] <= h_raw[gi];
                    h_s2[gi] <= h_s1[gi];
                    h_s3[gi] <= h_s2[gi];
                    if (h_s2[gi] == h_s3[gi]) begin
                        h_ok[gi] <= h_s3[gi];
                    end
                end
            end
        end
    endgenerate

    assign ebuf_err = h_ok[4] | h_ok[5];
    assign rx_bad   = h_ok[0] | h_ok[1] | h_ok[2] | h_ok[3] | ebuf_err;

    assign lf_column   = {`XFR_SEQ_LF_LANE3, 16'h0000, `XFR_SEQ_CHAR};
    assign rf_column   = {`XFR_SEQ_RF_LANE3, 16'h0000, `XFR_SEQ_CHAR};
    assign idle_column = {4{`XFR_IDLE_CHAR}};

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    logic [31:0] next_rxd;
    logic [3:0]  next_rxc;

    assign next_rxd = rx_bad ? lf_column : pcs_rxd;
    assign next_rxc = rx_bad ? 4'h1 : pcs_rxc;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mac_rxd <= 32'h0000_0000;
            mac_rxc <= 4'h0;
        end else begin
            mac_rxd <= next_rxd;
            mac_rxc <= next_rxc;
        end
    end

    xfr_pkg::xfr_fault_t rx_fault;

    xfr_seq_detect u_detect (
        .clock   (clock),
        .reset_n (reset_n),
        .rx_data (mac_rxd),
        .rx_ctrl (mac_rxc),
        .fault   (rx_fault)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [3:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic       wr_en;
    logic       rd_en;
    logic       hit_ctrl;
    logic       hit_status;
    logic       hit_latch;
    logic       hit_istat;
    logic       hit_imask;
    logic       hit_any;
    logic       rf_disable;
    logic       lf_clr;
    logic       ls_clr;
    logic       pcs_reset;

    assign wr_en      = psel & penable & pwrite;
    assign rd_en      = psel & penable & ~pwrite;
    assign hit_ctrl   = paddr == `XFR_OFS_CTRL;
    assign hit_status = paddr == `XFR_OFS_STATUS;
    assign hit_latch  = paddr == `XFR_OFS_LATCH;
    assign hit_istat  = paddr == `XFR_OFS_IRQ_STAT;
    assign hit_imask  = paddr == `XFR_OFS_IRQ_MASK;
    assign hit_any    = hit_ctrl | hit_status | hit_latch | hit_istat | hit_imask;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~hit_any;

    // Clear bits act as one-cycle pulses on the write strobe
    assign rf_disable = ctrl[`XFR_CTRL_RF_DIS];
    assign lf_clr     = wr_en & hit_ctrl & pwdata[`XFR_CTRL_LF_CLR];
    assign ls_clr     = wr_en & hit_ctrl & pwdata[`XFR_CTRL_LS_CLR];
    assign pcs_reset  = wr_en & hit_ctrl & pwdata[`XFR_CTRL_PCS_RST];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= `XFR_CTRL_RESET;
        end else if (wr_en && hit_ctrl) begin
            ctrl <= {1'b0, 2'b00, pwdata[`XFR_CTRL_RF_DIS]};
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask <= `XFR_IRQ_RESET;
        end else if (wr_en && hit_imask) begin
            irq_mask <= pwdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Live and latched status
    // ------------------------------------------------------------
    logic rd_latch;
    logic next_lf_lat;
    logic next_ls_lat;
    logic link_rise;
    logic link_prev;

    assign local_fault = rx_bad | (rx_fault == xfr_pkg::XFR_LOCAL_FLT);
    assign link_status = ~local_fault && rx_fault == xfr_pkg::XFR_LINK_OK;
    assign rd_latch    = rd_en & hit_latch;

    // Set wins over clear: an event in the clearing cycle is kept
    assign next_lf_lat = local_fault |
                         (local_fault_latched & ~(lf_clr | rd_latch | pcs_reset));
    // Latched link status is low-latching: any drop holds zero
    assign next_ls_lat = link_status &
                         (link_status_latched | ls_clr | rd_latch | pcs_reset);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            local_fault_latched <= 1'b1;
            link_status_latched <= 1'b0;
            link_prev           <= 1'b0;
        end else begin
            local_fault_latched <= next_lf_lat;
            link_status_latched <= next_ls_lat;
            link_prev           <= link_status;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [2:0] irq_evt;
    logic [2:0] irq_w1c;

    assign link_rise = link_status & ~link_prev;
    assign irq_evt   = {link_rise, rx_fault == xfr_pkg::XFR_REMOTE_FLT, local_fault};
    assign irq_w1c   = (wr_en && hit_istat) ? pwdata[2:0] : 3'h0;
    assign irq       = |(irq_stat & irq_mask);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat <= `XFR_IRQ_RESET;
        end else begin
            irq_stat <= irq_evt | (irq_stat & ~irq_w1c);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    logic [31:0] st_word;
    logic [31:0] lat_word;

    assign st_word  = {28'h000_0000, rx_fault == xfr_pkg::XFR_LOCAL_FLT,
                       rx_fault == xfr_pkg::XFR_REMOTE_FLT, link_status, local_fault};
    assign lat_word = {30'h0000_0000, link_status_latched, local_fault_latched};
    assign rd_mux   = hit_ctrl   ? {28'h000_0000, ctrl} :
                      hit_status ? st_word :
                      hit_latch  ? lat_word :
                      hit_istat  ? {29'h0000_0000, irq_stat} :
                      hit_imask  ? {29'h0000_0000, irq_mask} : 32'h0000_0000;
    assign prdata   = rd_mux;

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    logic [31:0] next_txd;
    logic [3:0]  next_txc;

    // Remote fault only ever comes from a received local fault
    always_comb begin
        next_txd = mac_txd;
        next_txc = mac_txc;
        case (rx_fault)
            xfr_pkg::XFR_LOCAL_FLT: begin
                if (rf_disable) begin
                    next_txd = idle_column;
                    next_txc = 4'hF;
                end else begin
                    next_txd = rf_column;
                    next_txc = 4'h1;
                end
            end
            xfr_pkg::XFR_REMOTE_FLT: begin
                next_txd = idle_column;
                next_txc = 4'hF;
            end
            xfr_pkg::XFR_LINK_OK: begin
                next_txd = mac_txd;
                next_txc = mac_txc;
            end
            default: begin
                next_txd = idle_column;
                next_txc = 4'hF;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pcs_txd <= {4{`XFR_IDLE_CHAR}};
            pcs_txc <= 4'hF;
        end else begin
            pcs_txd <= next_txd;
            pcs_txc <= next_txc;
        end
    end
endmodule
`default_nettype wire

// [verif/xfr_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module xfr_monitor (
    // Clock, reset, APB
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Receiver health
    input wire logic        xcvr_locked,
    input wire logic        rx_reset_active,
    input wire logic        block_lock,
    input wire logic        hi_ber,
    input wire logic        ebuf_overflow,
    input wire logic        ebuf_underflow,
    // Columns and status
    input wire logic [31:0] mac_rxd,
    input wire logic [3:0]  mac_rxc,
    input wire logic [31:0] mac_txd,
    input wire logic [3:0]  mac_txc,
    input wire logic [31:0] pcs_txd,
    input wire logic [3:0]  pcs_txc,
    input wire logic        local_fault,
    input wire logic        link_status,
    input wire logic        local_fault_latched,
    input wire logic        link_status_latched
);
    logic rf_dis;
    wire  wr_ctl = psel && penable && pwrite && paddr == 12'h000;
    wire  rd_lat = psel && penable && !pwrite && paddr == 12'h008;
    wire  clr_ev = (wr_ctl && (pwdata[1] || pwdata[3])) || rd_lat;
    wire  lf_col = mac_rxc == 4'h1 && mac_rxd == 32'h0100_009C;
    wire  rf_col = mac_rxc == 4'h1 && mac_rxd == 32'h0200_009C;
    wire  ok_col = !(mac_rxc[0] && mac_rxd[7:0] == 8'h9C);
    wire  bad_h  = !xcvr_locked || rx_reset_active || !block_lock || hi_ber;
    wire  idle   = pcs_txd == 32'h0707_0707 && pcs_txc == 4'hF;
    // Shadow of the suppress option, follows CTRL writes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rf_dis <= 1'b0;
        end else if (wr_ctl) begin
            rf_dis <= pwdata[0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_lf_on; (lf_col && !rf_dis) [*8]; endsequence
    sequence s_lf_off; (lf_col && rf_dis) [*8]; endsequence
    property p_health; bad_h [*7] |-> local_fault && lf_col; endproperty
    property p_ebuf; (ebuf_overflow || ebuf_underflow) [*7] |-> local_fault; endproperty
    property p_down; local_fault |-> !link_status; endproperty
    property p_lf_tx; s_lf_on |-> pcs_txd == 32'h0200_009C && pcs_txc == 4'h1; endproperty
    property p_rf_off; s_lf_off |-> idle; endproperty
    property p_rf_rx; rf_col [*8] |-> idle; endproperty
    property p_pass;
        (ok_col && !local_fault) [*8] |-> pcs_txd == $past(mac_txd) && pcs_txc == $past(mac_txc);
    endproperty
    property p_lf_lat; local_fault |=> local_fault_latched; endproperty
    property p_ls_lat; !link_status |=> !link_status_latched; endproperty
    property p_clr; $fell(local_fault_latched) |-> $past(clr_ev); endproperty
    a_health: assert property (p_health) else $error("receiver fault not raised");
    a_ebuf: assert property (p_ebuf) else $error("buffer error not raised");
    a_down: assert property (p_down) else $error("link up during fault");
    a_lf_tx: assert property (p_lf_tx) else $error("remote fault not sent");
    a_rf_off: assert property (p_rf_off) else $error("suppressed send wrong");
    a_rf_rx: assert property (p_rf_rx) else $error("idles not sent");
    a_pass: assert property (p_pass) else $error("transmit not passed");
    a_lf_lat: assert property (p_lf_lat) else $error("fault not latched");
    a_ls_lat: assert property (p_ls_lat) else $error("link low not latched");
    a_clr: assert property (p_clr) else $error("latch cleared by itself");
endmodule

bind xfr_reconcile xfr_monitor i_mon (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .xcvr_locked, .rx_reset_active, .block_lock, .hi_ber, .ebuf_overflow,
    .ebuf_underflow, .mac_rxd, .mac_rxc, .mac_txd, .mac_txc, .pcs_txd, .pcs_txc,
    .local_fault, .link_status, .local_fault_latched, .link_status_latched);
`default_nettype wire

// [verif/xfr_link_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module xfr_link_partner (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // 0 idle, 1 local fault, 2 remote fault
    input  wire logic [1:0]  mode,
    // Column towards the block
    output logic      [31:0] pcs_rxd,
    output logic      [3:0]  pcs_rxc
);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pcs_rxd <= 32'h0707_0707;
            pcs_rxc <= 4'hF;
        end else begin
            pcs_rxc <= (mode == 2'h0) ? 4'hF : 4'h1;
            pcs_rxd <= (mode == 2'h1) ? 32'h0100_009C :
                       (mode == 2'h2) ? 32'h0200_009C : 32'h0707_0707;
        end
    end
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clock, reset_n, psel, penable, pwrite, pready, pslverr, err, irq, irq_a;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, mac_rxd, pcs_rxd, mac_txd, pcs_txd;
    logic [3:0]  mac_rxc, pcs_rxc, mac_txc, pcs_txc;
    logic [5:0]  hv;
    logic [1:0]  pm;
    logic        local_fault, link_status, lf_lat, ls_lat;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    localparam logic [35:0] IDLE = 36'hF_0707_0707;
    localparam logic [35:0] RFC = 36'h1_0200_009C;
    localparam logic [35:0] PASS = 36'h0_1234_5678;
    // Health {locked, in reset, block lock, hi ber, overflow, underflow}, expected fault
    localparam logic [6:0] ROWS [7] = '{7'h50, 7'h11, 7'h71, 7'h41, 7'h59, 7'h55, 7'h53};

    xfr_reconcile i_dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xcvr_locked(hv[5]), .rx_reset_active(hv[4]), .block_lock(hv[3]),
        .hi_ber(hv[2]), .ebuf_overflow(hv[1]), .ebuf_underflow(hv[0]), .pcs_rxd(pcs_rxd),
        .pcs_rxc(pcs_rxc), .mac_rxd(mac_rxd), .mac_rxc(mac_rxc), .mac_txd(mac_txd),
        .mac_txc(mac_txc), .pcs_txd(pcs_txd), .pcs_txc(pcs_txc), .local_fault(local_fault),
        .link_status(link_status), .local_fault_latched(lf_lat),
        .link_status_latched(ls_lat), .irq(irq));
    xfr_link_partner i_lp (.clock(clock), .reset_n(reset_n), .mode(pm), .pcs_rxd(pcs_rxd),
        .pcs_rxc(pcs_rxc));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ----------------
    // Helpers
    // ----------------
    task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never reassigns psel in this step
        @(posedge clock);
    endtask
    task automatic results;
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            results();
        end
    end
    // ----------------
    // Sequence
    // ----------------
    initial begin
        reset_n <= 1'b0;
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        hv <= 6'h28;
        pm <= 2'h0;
        mac_txd <= 32'h1234_5678;
        mac_txc <= 4'h0;
        tick(5);
        chk("rst_tx", {pcs_txc, pcs_txd}, IDLE);
        chk("rst_link", link_status, 0);
        chk("rst_lat", {ls_lat, lf_lat, local_fault}, 3'b011);
        reset_n <= 1'b1;
        tick(1);
        apb(0, 12'h000, 0);
        chk("ctrl_rst", rd, 0);
        foreach (ROWS[i]) begin
            hv <= ROWS[i][6:1];
            tick(14);
            chk("lf", local_fault, ROWS[i][0]);
            chk("link", link_status, !ROWS[i][0]);
            chk("rxcol", {mac_rxc, mac_rxd}, ROWS[i][0] ? 36'h1_0100_009C : IDLE);
            hv <= 6'h28;
            tick(14);
            chk("link_up", link_status, 1);
        end
        apb(0, 12'h008, 0);
        pm <= 2'h1;
        tick(12);
        chk("tx_rf", {pcs_txc, pcs_txd}, RFC);
        apb(1, 12'h000, 1);
        tick(10);
        chk("tx_sup", {pcs_txc, pcs_txd}, IDLE);
        apb(1, 12'h000, 0);
        tick(3);
        chk("tx_rf2", {pcs_txc, pcs_txd}, RFC);
        pm <= 2'h0;
        tick(12);
        chk("tx_pass", {pcs_txc, pcs_txd}, PASS);
        apb(0, 12'h008, 0);
        chk("lat1", rd[1:0], 2'b01);
        apb(0, 12'h008, 0);
        chk("lat2", rd[1:0], 2'b10);
        apb(0, 12'h00C, 0);
        chk("istat", rd[0], 1);
        apb(1, 12'h010, 0);
        tick(1);
        irq_a = irq;
        apb(1, 12'h010, 7);
        tick(1);
        chk("irq_mask", irq_a ^ irq, 1);
        apb(1, 12'h00C, 7);
        tick(1);
        chk("irq_clr", irq, 0);
        pm <= 2'h2;
        tick(12);
        chk("tx_idle", {pcs_txc, pcs_txd}, IDLE);
        pm <= 2'h0;
        tick(12);
        chk("tx_back", {pcs_txc, pcs_txd}, PASS);
        // Each clear bit in turn: 1 fault latch, 2 link latch, 3 both
        for (int k = 1; k < 4; k++) begin
            hv <= 6'h08;
            tick(10);
            hv <= 6'h28;
            tick(16);
            chk("lat_hold", {ls_lat, lf_lat}, 2'b01);
            apb(1, 12'h000, 32'h1 << k);
            tick(1);
            chk("lat_clr", {ls_lat, lf_lat}, {k != 1, k == 2});
        end
        apb(0, 12'h020, 0);
        chk("unmapped", {err, rd}, 36'h1_0000_0000);
        results();
    end
endmodule
`default_nettype wire
